// *** bsp_pkg.sv ***
// Purpose: Shared constants and carrier types for the shared-port and slave-port block.
// Assumes: AXI4-Lite register access with 32-bit data, one register per aligned word.
// Notes:   Byte addresses, field positions and reset values live here, except those of remap and the slave-port flags.
package bsp_pkg;

    // ************************************************************
    // Register byte addresses
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_HI_DIR = 8'h00;
    localparam logic [7:0] OFS_HI_PINS = 8'h04;
    localparam logic [7:0] OFS_HI_LATCH = 8'h08;
    localparam logic [7:0] OFS_BC_PINS = 8'h0c;
    localparam logic [7:0] OFS_BC_LATCH = 8'h10;
    localparam logic [7:0] OFS_BC_DIR = 8'h14;
    localparam logic [7:0] OFS_SP_CTRL = 8'h18;
    localparam logic [7:0] OFS_SP_DATA = 8'h1c;
    localparam logic [7:0] OFS_MEM_CTRL = 8'h20;
    localparam logic [7:0] OFS_ANA_CFG = 8'h24;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int SP_FULL_BIT = 7;
    localparam int SP_OBF_BIT = 6;
    localparam int SP_OVF_BIT = 5;
    localparam int SP_MODE_BIT = 4;
    localparam int MEM_BUS_DIS_BIT = 7;
    localparam int ANA_REMAP_BIT = 7;
    localparam int ANA_HI_LSB = 3;
    localparam int ANA_PCFG_LSB = 0;

    // ************************************************************
    // Reset values, response codes and synchroniser width
    // ************************************************************
    localparam logic [7:0] RST_DIR = 8'hff;
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [3:0] RST_ANA_HI = 4'hf;
    localparam logic [2:0] RST_PCFG = 3'h0;
    localparam logic RST_BUS_DIS = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int SYNC_W = 27;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
    } bsp_pin_drv_t;

    typedef struct packed {
        logic [3:0] ttl_hi;
        logic ttl_ctl;
        logic [3:0] analog_hi;
        logic [2:0] digital_ctl;
    } bsp_buf_cfg_t;

endpackage : bsp_pkg

// *** bsp_ports.sv ***
// Purpose: Two shared I/O ports (high address, bus control) plus the 8-bit parallel slave port.
// Assumes: One 250 MHz clock; slave strobes and all pins are asynchronous and synchronised here.
// Notes:   Peripheral overrides act on the pin drivers only, never on the stored direction.
// Contract
// - Bus-control direction bit one makes that pin's driver high impedance.
// - Bus-control direction bit zero drives the pin from its latch bit.
// - Latch register reads return stored latch value, not pin level.
// - Bus-control port is general I/O only while the external bus is off.
// - Bus mode puts the eight memory strobes on bits 0..7 in fixed order.
// - Bus mode drives high-address bits 0..3 with address 16..19, else I/O.
// - High-address bits 4..7 are I/O, analog 12..15 or PWM outputs.
// - Low high-address pins use Schmitt in I/O, TTL in bus or slave mode.
// - PWM outputs use high-address pins when remap clear, alternate pins when set.
// - Peripheral direction override never alters the stored direction register.
// - Slave-port mode bit makes the data port an async 8-bit slave port.
// - Slave mode uses control pins 0,1,2 as active-low read, write, select.
// - Slave write happens when select and write are first seen low together.
// - Slave read happens when select and read are first seen low together.
// - Slave-mode control inputs use TTL buffers.
// - Slave port works only with the external memory bus unused.
// - Received word sets full flag; write before read sets overflow, software clears.
// - Memory control picks I/O or bus for low high-address pins; bus at reset.
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module bsp_ports (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [bsp_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [bsp_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // External memory interface signals to place on the pins
    input wire logic [7:0] emi_ctrl,
    input wire logic [3:0] emi_addr_hi,
    // PWM outputs: order pwm3_output_c, pwm3_output_b, pwm1_output_c, pwm1_output_b
    input wire logic [3:0] pwm_out,
    input wire logic [3:0] pwm_en,
    output bsp_pkg::bsp_pin_drv_t pwm_alt_drv,
    // High-address port pins
    input wire logic [7:0] high_addr_pin_i,
    output bsp_pkg::bsp_pin_drv_t high_addr_drv,
    // Bus-control port pins
    input wire logic [7:0] bus_ctrl_pin_i,
    output bsp_pkg::bsp_pin_drv_t bus_ctrl_drv,
    // Slave data port pins and control strobes
    input wire logic [7:0] slave_data_pin_i,
    output bsp_pkg::bsp_pin_drv_t slave_data_drv,
    input wire logic slave_rd_n,
    input wire logic slave_wr_n,
    input wire logic slave_cs_n,
    // Input buffer and analog selection towards the pads
    output bsp_pkg::bsp_buf_cfg_t buf_cfg
);
    import bsp_pkg::*;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [SYNC_W-1:0] sync_meta;
    logic [SYNC_W-1:0] sync_out;
    logic [7:0] hi_pin_s;
    logic [7:0] bc_pin_s;
    logic [7:0] sd_pin_s;
    logic rd_n_s;
    logic wr_n_s;
    logic cs_n_s;

    // Two stages on every outside level; only the second stage is read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_meta <= '1;
            sync_out <= '1;
        end else begin
            sync_meta <= {high_addr_pin_i, bus_ctrl_pin_i, slave_data_pin_i, slave_rd_n, slave_wr_n, slave_cs_n};
            sync_out <= sync_meta;
        end
    end
    assign {hi_pin_s, bc_pin_s, sd_pin_s, rd_n_s, wr_n_s, cs_n_s} = sync_out;

    // ************************************************************
    // Bus channel state
    // ************************************************************
    logic aw_held, next_aw_held;
    logic w_held, next_w_held;
    logic [ADDR_W-1:0] awaddr_q, next_awaddr_q;
    logic [7:0] wdata_q, next_wdata_q;
    logic wstrb_q, next_wstrb_q;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;
    logic ar_fire;
    logic wr_do;
    logic [7:0] rd_val;
    logic rd_hit;
    logic wr_hit;

    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign s_axi_arready = !rvalid;
    assign ar_fire = s_axi_arvalid && !rvalid;
    // Commit one cycle after both halves are held; a pending response blocks the next commit
    assign wr_do = aw_held && w_held && !bvalid;

    // ************************************************************
    // Register and slave-port state
    // ************************************************************
    logic [7:0] hi_dir, next_hi_dir;
    logic [7:0] hi_latch, next_hi_latch;
    logic [7:0] bc_dir, next_bc_dir;
    logic [7:0] bc_latch, next_bc_latch;
    logic bus_dis, next_bus_dis;
    logic [3:0] ana_hi, next_ana_hi;
    logic [2:0] pcfg, next_pcfg;
    logic remap, next_remap;
    logic sp_mode, next_sp_mode;
    logic in_full, next_in_full;
    logic obf, next_obf;
    logic in_ovf, next_in_ovf;
    logic [7:0] sp_in, next_sp_in;
    logic [7:0] sp_out, next_sp_out;
    logic wr_low_q, next_wr_low_q;
    logic rd_low_q, next_rd_low_q;
    logic sp_on;
    logic wr_low;
    logic rd_low;
    logic sp_wr_start;
    logic sp_rd_start;

    // Slave port only without the external bus
    assign sp_on = sp_mode && bus_dis;
    assign wr_low = sp_on && !cs_n_s && !wr_n_s;
    assign rd_low = sp_on && !cs_n_s && !rd_n_s;
    // First cycle of the joint low level; a held strobe counts once
    assign sp_wr_start = wr_low && !wr_low_q;
    assign sp_rd_start = rd_low && !rd_low_q;
    assign wr_hit = wr_do && wstrb_q;

    // Read mux; pin registers show pin level except analog high-address bits, which read zero; latch registers show the latch
    always_comb begin
        rd_hit = 1'b1;
        rd_val = 8'h00;
        unique case (s_axi_araddr)
            OFS_HI_DIR: rd_val = hi_dir;
            OFS_HI_PINS: rd_val = hi_pin_s & {~ana_hi, 4'hf};
            OFS_HI_LATCH: rd_val = hi_latch;
            OFS_BC_PINS: rd_val = bc_pin_s;
            OFS_BC_LATCH: rd_val = bc_latch;
            OFS_BC_DIR: rd_val = bc_dir;
            OFS_SP_CTRL: rd_val = {in_full, obf, in_ovf, sp_mode, 4'h0};
            OFS_SP_DATA: rd_val = sp_in;
            OFS_MEM_CTRL: rd_val = {bus_dis, 7'h00};
            OFS_ANA_CFG: rd_val = {remap, ana_hi, pcfg};
            default: rd_hit = 1'b0;
        endcase
    end

    // Bus channel next state
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_awaddr_q = awaddr_q;
        next_wdata_q = wdata_q;
        next_wstrb_q = wstrb_q;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (s_axi_awvalid && !aw_held) begin
            next_aw_held = 1'b1;
            next_awaddr_q = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held) begin
            next_w_held = 1'b1;
            next_wdata_q = s_axi_wdata[7:0];
            next_wstrb_q = s_axi_wstrb[0];
        end
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (wr_do) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = (awaddr_q[1:0] == 2'h0 && awaddr_q <= OFS_ANA_CFG) ? RESP_OKAY : RESP_SLVERR;
        end
        if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (ar_fire) begin
            next_rvalid = 1'b1;
            next_rdata = {24'h000000, rd_val};
            next_rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 8'h00;
            wstrb_q <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            awaddr_q <= next_awaddr_q;
            wdata_q <= next_wdata_q;
            wstrb_q <= next_wstrb_q;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;

    // Register and slave-port next state; hardware sets win over software clears
    always_comb begin
        next_hi_dir = hi_dir;
        next_hi_latch = hi_latch;
        next_bc_dir = bc_dir;
        next_bc_latch = bc_latch;
        next_bus_dis = bus_dis;
        next_ana_hi = ana_hi;
        next_pcfg = pcfg;
        next_remap = remap;
        next_sp_mode = sp_mode;
        next_in_full = in_full;
        next_obf = obf;
        next_in_ovf = in_ovf;
        next_sp_in = sp_in;
        next_sp_out = sp_out;
        next_wr_low_q = wr_low;
        next_rd_low_q = rd_low;
        if (wr_hit) begin
            unique case (awaddr_q)
                OFS_HI_DIR: next_hi_dir = wdata_q;
                OFS_HI_PINS, OFS_HI_LATCH: next_hi_latch = wdata_q;
                OFS_BC_PINS, OFS_BC_LATCH: next_bc_latch = wdata_q;
                OFS_BC_DIR: next_bc_dir = wdata_q;
                OFS_SP_CTRL: begin
                    next_in_ovf = wdata_q[SP_OVF_BIT];
                    next_sp_mode = wdata_q[SP_MODE_BIT];
                end
                OFS_SP_DATA: begin
                    next_sp_out = wdata_q;
                    next_obf = 1'b1;
                end
                OFS_MEM_CTRL: next_bus_dis = wdata_q[MEM_BUS_DIS_BIT];
                OFS_ANA_CFG: begin
                    next_remap = wdata_q[ANA_REMAP_BIT];
                    next_ana_hi = wdata_q[ANA_HI_LSB +: 4];
                    next_pcfg = wdata_q[ANA_PCFG_LSB +: 3];
                end
                default: begin
                end
            endcase
        end
        // Software reading the received word empties the input buffer
        if (ar_fire && s_axi_araddr == OFS_SP_DATA) begin
            next_in_full = 1'b0;
        end
        if (sp_wr_start) begin
            next_sp_in = sd_pin_s;
            next_in_full = 1'b1;
            if (in_full) begin
                next_in_ovf = 1'b1;
            end
        end
        if (sp_rd_start) begin
            next_obf = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hi_dir <= RST_DIR;
            hi_latch <= RST_LATCH;
            bc_dir <= RST_DIR;
            bc_latch <= RST_LATCH;
            bus_dis <= RST_BUS_DIS;
            ana_hi <= RST_ANA_HI;
            pcfg <= RST_PCFG;
            remap <= 1'b0;
            sp_mode <= 1'b0;
            in_full <= 1'b0;
            obf <= 1'b0;
            in_ovf <= 1'b0;
            sp_in <= RST_LATCH;
            sp_out <= RST_LATCH;
            wr_low_q <= 1'b0;
            rd_low_q <= 1'b0;
        end else begin
            hi_dir <= next_hi_dir;
            hi_latch <= next_hi_latch;
            bc_dir <= next_bc_dir;
            bc_latch <= next_bc_latch;
            bus_dis <= next_bus_dis;
            ana_hi <= next_ana_hi;
            pcfg <= next_pcfg;
            remap <= next_remap;
            sp_mode <= next_sp_mode;
            in_full <= next_in_full;
            obf <= next_obf;
            in_ovf <= next_in_ovf;
            sp_in <= next_sp_in;
            sp_out <= next_sp_out;
            wr_low_q <= next_wr_low_q;
            rd_low_q <= next_rd_low_q;
        end
    end

    // ************************************************************
    // Pin drivers; overrides stay out of the direction registers
    // ************************************************************
    always_comb begin
        // Bus-control port: memory strobes in bus mode, general I/O otherwise
        if (!bus_dis) begin
            bus_ctrl_drv.o = emi_ctrl;
            bus_ctrl_drv.oe = 8'hff;
        end else begin
            bus_ctrl_drv.o = bc_latch;
            bus_ctrl_drv.oe = ~bc_dir;
        end
        // High-address low nibble: upper address bits or I/O
        if (!bus_dis) begin
            high_addr_drv.o[3:0] = emi_addr_hi;
            high_addr_drv.oe[3:0] = 4'hf;
        end else begin
            high_addr_drv.o[3:0] = hi_latch[3:0];
            high_addr_drv.oe[3:0] = ~hi_dir[3:0];
        end
        // High nibble: analog wins, then PWM when not remapped, then I/O
        for (int i = 0; i < 4; i++) begin
            if (ana_hi[i]) begin
                high_addr_drv.o[4+i] = 1'b0;
                high_addr_drv.oe[4+i] = 1'b0;
            end else if (pwm_en[i] && !remap) begin
                high_addr_drv.o[4+i] = pwm_out[i];
                high_addr_drv.oe[4+i] = 1'b1;
            end else begin
                high_addr_drv.o[4+i] = hi_latch[4+i];
                high_addr_drv.oe[4+i] = !hi_dir[4+i];
            end
        end
    end

    // Alternate PWM pins and slave data bus
    assign pwm_alt_drv.o = {4'h0, pwm_out};
    assign pwm_alt_drv.oe = {4'h0, pwm_en & {4{remap}}};
    assign slave_data_drv.o = sp_out;
    assign slave_data_drv.oe = {8{rd_low}};

    // Pad buffer selection; TTL only needed where an outside bus is sampled
    assign buf_cfg.ttl_hi = {4{!bus_dis || sp_on}};
    assign buf_cfg.ttl_ctl = sp_on;
    assign buf_cfg.analog_hi = ana_hi;
    assign buf_cfg.digital_ctl = pcfg;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence sp_write_seen;
        sp_on && !cs_n_s && !wr_n_s && !wr_low_q;
    endsequence

    sequence sp_word_held(logic [7:0] d);
        in_full && sp_in == d;
    endsequence

    dir_hiz_a: assert property (bus_dis |-> (bus_ctrl_drv.oe & bc_dir) == 8'h00)
        else $error("bus-control enable not from direction");
    dir_drive_a: assert property (bus_dis |-> (((bus_ctrl_drv.o ^ bc_latch) | ~bus_ctrl_drv.oe) & ~bc_dir) == 8'h00)
        else $error("bus-control output not from latch");
    latch_read_a: assert property (ar_fire && s_axi_araddr == OFS_BC_LATCH |=> rdata[7:0] == $past(bc_latch))
        else $error("latch read returned wrong value");
    bus_strobes_a: assert property (!bus_dis |-> bus_ctrl_drv.o == emi_ctrl && bus_ctrl_drv.oe == 8'hff)
        else $error("bus-control pins not carrying strobes");
    addr_hi_a: assert property (!bus_dis |-> high_addr_drv.o[3:0] == emi_addr_hi)
        else $error("upper address bits missing");
    pwm_remap_a: assert property (remap |-> (pwm_alt_drv.oe[3:0] == pwm_en))
        else $error("remapped PWM not on alternate pins");
    dir_keep_a: assert property (!(wr_hit && awaddr_q == OFS_BC_DIR) |=> $stable(bc_dir))
        else $error("direction changed without a write");
    sp_write_a: assert property (sp_write_seen |=> sp_word_held($past(sd_pin_s)))
        else $error("slave write not captured");
    sp_once_a: assert property (sp_wr_start |=> !sp_wr_start)
        else $error("slave write counted twice");
    sp_read_a: assert property (sp_rd_start |-> slave_data_drv.oe == 8'hff ##1 !obf)
        else $error("slave read not served");
    ovf_set_a: assert property (sp_wr_start && in_full |=> in_ovf)
        else $error("overflow not flagged");
    ttl_sel_a: assert property (sp_on |-> buf_cfg.ttl_ctl && buf_cfg.ttl_hi == 4'hf)
        else $error("slave mode without TTL buffers");
    bus_reset_a: assert property ($past(!aresetn) |-> !bus_dis && !sp_on)
        else $error("bus mode not default after reset");

endmodule : bsp_ports

// *** bsp_ext_cpu.sv ***
// Purpose: External 8-bit processor on the slave port strobes and data lines
// Assumes: Strobes change just after a rising edge of aclk
// Notes:   Released data is held for 3 cycles, then shows the inverse of the last byte
`timescale 1ns/1ps
module bsp_ext_cpu (
    // Clock
    input wire logic aclk,
    // Strobes and data towards the pads
    output logic rd_n,
    output logic wr_n,
    output logic cs_n,
    output logic [7:0] dq,
    input wire logic [7:0] pin
);
    // Idle: strobes high
    initial begin
        rd_n = 1'b1;
        wr_n = 1'b1;
        cs_n = 1'b1;
        dq = 8'h00;
    end

    // One whole byte, set up before select, held past release
    task automatic cpu_write(input logic [7:0] d, input int hold);
        dq <= d;
        repeat (3) @(posedge aclk);
        cs_n <= 1'b0;
        wr_n <= 1'b0;
        repeat (hold) @(posedge aclk);
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        repeat (3) @(posedge aclk);
        dq <= ~d;
        repeat (2) @(posedge aclk);
    endtask : cpu_write

    // Read: select and read low together, sample once settled
    task automatic cpu_read(output logic [7:0] d);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        repeat (5) @(posedge aclk);
        @(negedge aclk);
        d = pin;
        @(posedge aclk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        repeat (4) @(posedge aclk);
    endtask : cpu_read
endmodule : bsp_ext_cpu

// *** bsp_ports_tb.sv ***
// Purpose: Self-checking bench for the shared ports and slave port
// Assumes: AXI4-Lite master waits for each handshake, no fixed latency
// Notes:   Pin levels are resolved here from the block's drive and enables
`timescale 1ns/1ps
module bsp_ports_tb;
    import bsp_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, rd8;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [3:0] pwm_out = 4'h0, pwm_en = 4'h0;
    logic [7:0] hi_pin, bc_pin, sd_pin, dq;
    logic rd_n, wr_n, cs_n;
    bsp_pin_drv_t alt, hi, bc, sd;
    bsp_buf_cfg_t bcfg;
    int fail_count = 0, checks = 0;
    logic [23:0] rows [6] = '{{OFS_BC_LATCH, 16'ha5a5}, {OFS_BC_DIR, 16'h0f0f}, {OFS_HI_LATCH, 16'h3c3c},
        {OFS_HI_DIR, 16'hf0f0}, {OFS_MEM_CTRL, 16'h8080}, {OFS_ANA_CFG, 16'h0000}};
    // Pads: driven bits win, else a fixed outside level, or the external CPU's dq on the slave data pins
    assign bc_pin = (bc.o & bc.oe) | (8'h5a & ~bc.oe);
    assign hi_pin = (hi.o & hi.oe) | (8'h66 & ~hi.oe);
    assign sd_pin = (sd.o & sd.oe) | (dq & ~sd.oe);

    bsp_ports uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .emi_ctrl(8'hc3),
        .emi_addr_hi(4'h9), .pwm_out(pwm_out), .pwm_en(pwm_en), .pwm_alt_drv(alt), .high_addr_pin_i(hi_pin),
        .high_addr_drv(hi), .bus_ctrl_pin_i(bc_pin), .bus_ctrl_drv(bc), .slave_data_pin_i(sd_pin),
        .slave_data_drv(sd), .slave_rd_n(rd_n), .slave_wr_n(wr_n), .slave_cs_n(cs_n), .buf_cfg(bcfg));
    bsp_ext_cpu ext (.aclk(aclk), .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n), .dq(dq), .pin(sd_pin));

    // ************************************************************
    // Checking and bus tasks
    // ************************************************************
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // Handshakes judged mid-cycle, so the edge sees the same levels
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ha, hw, hb;
        // Start after an edge, so the previous transfer's release is seen first
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid;
            if (hb) chk("bresp", bresp, er);
            @(posedge aclk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
        end while (!hb);
        bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input string n, input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        logic ha, hr;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            ha = arvalid && arready;
            hr = rvalid;
            if (hr) chk(n, {rresp, rdata[29:0]}, {er, 22'h0, e});
            @(posedge aclk);
            if (ha) arvalid <= 1'b0;
        end while (!hr);
        rready <= 1'b0;
    endtask : axi_rd
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    // ************************************************************
    // Clock, watchdog, sequence
    // ************************************************************
    initial begin
        forever #2 aclk = ~aclk;
    end
    // Whole run needs a few hundred cycles; far margin
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        give_verdict;
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Reset: bus on, inputs on direction, analog high nibble
        axi_rd("hi_dir", OFS_HI_DIR, RST_DIR, RESP_OKAY);
        axi_rd("bc_dir", OFS_BC_DIR, RST_DIR, RESP_OKAY);
        axi_rd("ana", OFS_ANA_CFG, 8'h78, RESP_OKAY);
        axi_rd("mem", OFS_MEM_CTRL, 8'h00, RESP_OKAY);
        chk("bc_bus", bc, {8'hc3, 8'hff});
        chk("hi_bus", hi, 16'h090f);
        chk("ttl_bus", bcfg.ttl_hi, 4'hf);
        // Slave port stays off while the memory bus is on
        axi_wr(OFS_SP_CTRL, 8'h10, RESP_OKAY);
        ext.cpu_write(8'h11, 4);
        axi_rd("sp_busy", OFS_SP_CTRL, 8'h10, RESP_OKAY);
        $display("test reset done");
        // Row table: write then read back
        foreach (rows[i]) axi_wr(rows[i][23:16], rows[i][15:8], RESP_OKAY);
        foreach (rows[i]) axi_rd("row", rows[i][23:16], rows[i][7:0], RESP_OKAY);
        $display("test rows done");
        // General I/O with bus off
        chk("bc_oe", bc.oe, 8'hf0);
        chk("bc_o", bc.o & bc.oe, 8'ha0);
        axi_rd("bc_pins", OFS_BC_PINS, 8'haa, RESP_OKAY);
        chk("hi_io", {hi.o[3:0], hi.oe[3:0]}, 8'hcf);
        // Slave mode is still on here, so TTL stays selected
        chk("ttl_sp", bcfg.ttl_hi, 4'hf);
        // PWM on high pins, then remapped away; direction untouched
        pwm_en <= 4'hf;
        pwm_out <= 4'ha;
        @(posedge aclk);
        @(negedge aclk);
        chk("pwm_hi", {hi.o[7:4], hi.oe[7:4]}, 8'haf);
        axi_rd("dir_kept", OFS_HI_DIR, 8'hf0, RESP_OKAY);
        axi_wr(OFS_ANA_CFG, 8'h87, RESP_OKAY);
        chk("dig", {bcfg.analog_hi, bcfg.digital_ctl}, 7'h07);
        chk("pwm_alt", {alt.o[3:0], alt.oe[3:0], hi.oe[7:4]}, 12'haf0);
        $display("test pwm done");
        // Slave writes: long strobe counts once, second write overflows
        chk("ttl_ctl", bcfg.ttl_ctl, 1'b1);
        ext.cpu_write(8'h96, 10);
        axi_rd("in_full", OFS_SP_CTRL, 8'h90, RESP_OKAY);
        axi_rd("word", OFS_SP_DATA, 8'h96, RESP_OKAY);
        ext.cpu_write(8'h01, 3);
        ext.cpu_write(8'h02, 3);
        axi_rd("in_ovf", OFS_SP_CTRL, 8'hb0, RESP_OKAY);
        axi_wr(OFS_SP_CTRL, 8'h10, RESP_OKAY);
        axi_rd("ovf_clr", OFS_SP_CTRL, 8'h90, RESP_OKAY);
        axi_rd("word2", OFS_SP_DATA, 8'h02, RESP_OKAY);
        // Slave read of the output word
        axi_wr(OFS_SP_DATA, 8'h3c, RESP_OKAY);
        axi_rd("obf", OFS_SP_CTRL, 8'h50, RESP_OKAY);
        ext.cpu_read(rd8);
        chk("rd_byte", rd8, 8'h3c);
        axi_rd("obf_clr", OFS_SP_CTRL, 8'h10, RESP_OKAY);
        $display("test slave done");
        // Unmapped place
        axi_wr(8'h40, 8'h55, RESP_SLVERR);
        axi_rd("unmapped", 8'h40, 8'h00, RESP_SLVERR);
        $display("test unmapped done");
        // Plain I/O: bus off, slave mode off, Schmitt buffers
        axi_wr(OFS_SP_CTRL, 8'h00, RESP_OKAY);
        chk("ttl_io", {bcfg.ttl_hi, bcfg.ttl_ctl}, 5'h00);
        // Second reset in mid-run
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd("rst_dir", OFS_BC_DIR, RST_DIR, RESP_OKAY);
        axi_rd("rst_mem", OFS_MEM_CTRL, 8'h00, RESP_OKAY);
        axi_rd("rst_sp", OFS_SP_CTRL, 8'h00, RESP_OKAY);
        chk("rst_bus", bc, 16'hc3ff);
        $display("test rerun reset done");
        give_verdict;
    end
endmodule : bsp_ports_tb
